// >>> compact_timer.v
// Compact 16-bit timer with compare-match, PWM and timer/counter modes
`timescale 1ns/1ns
`default_nettype none
`include "compact_timer_consts.vh"
module compact_timer (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Register port
  input wire [2:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output wire [7:0] rdata,
  // Counting clock sources
  input wire high_clk_tick,
  input wire time_base_tick,
  input wire external_count_input,
  // Output pin and flags
  output reg timer_output_pin,
  output reg timer_output_en,
  output reg match_a_flag,
  output reg match_p_flag
);
  wire [7:0] ctrl0;
  wire [7:0] ctrl1;
  wire [15:0] compare_a_value;
  wire [7:0] compare_p_value;
  wire [1:0] flag_clr;
  wire tick;
  reg [15:0] count_ff;
  reg run_d_ff;
  reg level_ff;
  reg [15:0] nxt_count;
  reg nxt_level;
  reg pin_raw;
  reg a_match;
  reg p_match;
  reg clr;
  reg set_a;
  reg set_p;
  reg pwm_on;

  wire run_enable = ctrl0[`CT_B_RUN];
  wire counter_pause = ctrl0[`CT_B_PAUSE];
  wire [2:0] count_clock_select = ctrl0[6:4];
  wire [1:0] mode = ctrl1[7:6];
  wire [1:0] output_action = ctrl1[5:4];
  wire output_initial_level = ctrl1[`CT_B_INIT];
  wire output_invert = ctrl1[`CT_B_INVERT];
  wire period_duty_swap = ctrl1[`CT_B_SWAP];
  wire clear_source_select = ctrl1[`CT_B_CLR_SRC];
  wire run_rise = run_enable && !run_d_ff;
  wire active = run_enable && !counter_pause && tick;

  compact_timer_regs u_regs (
    .ref_clk(ref_clk),
    .rst(rst),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata_ff(rdata),
    .count(count_ff),
    .flags({match_p_flag, match_a_flag}),
    .ctrl0_ff(ctrl0),
    .ctrl1_ff(ctrl1),
    .cmpa_ff(compare_a_value),
    .cmpp_ff(compare_p_value),
    .flag_clr(flag_clr)
  );

  compact_timer_tick u_tick (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(run_enable),
    .sel(count_clock_select),
    .high_clk_tick(high_clk_tick),
    .time_base_tick(time_base_tick),
    .external_count_input(external_count_input),
    .tick(tick)
  );

  // Match detection on the value reached after this tick
  always @* begin
    nxt_count = count_ff + 16'h0001;
    // P compares the top byte; zero means a full 65536 wrap
    // Nonzero P matches as the count reaches P*256, a 256*P period
    if (compare_p_value == 8'h00)
      p_match = (count_ff == 16'hffff);
    else
      p_match = (nxt_count == {compare_p_value, 8'h00});
    // A reaching zero never matches; counter wraps at FFFF
    a_match = (compare_a_value != 16'h0000) &&
              (nxt_count == compare_a_value);
    clr = 1'b0;
    set_a = 1'b0;
    set_p = 1'b0;
    if (active) begin
      if (mode == `CT_MODE_PWM) begin
        // Period source clears the counter
        clr = period_duty_swap ? a_match : p_match;
        set_a = a_match;
        set_p = p_match;
      end else if (clear_source_select) begin
        clr = a_match;
        set_a = a_match;
      end else begin
        clr = p_match;
        set_a = a_match;
        set_p = p_match;
      end
    end
  end

  // Compare-mode pin level and PWM waveform
  always @* begin
    nxt_level = level_ff;
    pwm_on = 1'b0;
    if (run_rise)
      nxt_level = output_initial_level;
    else if (mode == `CT_MODE_CMP && set_a) begin
      // Only A matches touch the pin
      case (output_action)
        `CT_ACT_LOW: nxt_level = 1'b0;
        `CT_ACT_HIGH: nxt_level = 1'b1;
        `CT_ACT_TOGGLE: nxt_level = !level_ff;
        default: nxt_level = level_ff;
      endcase
    end
    // Duty compare: duty at or above period gives full duty
    if (period_duty_swap)
      pwm_on = (compare_p_value == 8'h00) ||
               (count_ff < {compare_p_value, 8'h00});
    else
      pwm_on = (count_ff < compare_a_value) ||
               ((compare_p_value != 8'h00) &&
                (compare_a_value >= {compare_p_value, 8'h00}));
    pin_raw = level_ff;
    if (mode == `CT_MODE_PWM) begin
      // Initial level bit is the active polarity
      case (output_action)
        `CT_ACT_KEEP: pin_raw = !output_initial_level;
        `CT_ACT_LOW: pin_raw = output_initial_level;
        `CT_ACT_HIGH:
          pin_raw = (pwm_on && run_enable) ? output_initial_level :
                    !output_initial_level;
        default: pin_raw = !output_initial_level;
      endcase
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_ff <= 16'h0000;
      run_d_ff <= 1'b0;
      level_ff <= 1'b0;
      match_a_flag <= 1'b0;
      match_p_flag <= 1'b0;
      timer_output_pin <= 1'b0;
      timer_output_en <= 1'b0;
    end else begin
      run_d_ff <= run_enable;
      if (run_rise)
        count_ff <= 16'h0000;
      else if (active) begin
        if (clr)
          count_ff <= 16'h0000;
        else
          count_ff <= nxt_count;
      end
      level_ff <= nxt_level;
      // Set wins over a software clear in the same cycle
      match_a_flag <= set_a | (match_a_flag & ~flag_clr[`CT_B_FLAG_A]);
      match_p_flag <= set_p | (match_p_flag & ~flag_clr[`CT_B_FLAG_P]);
      // Timer mode leaves the pin to other functions
      timer_output_en <= (mode == `CT_MODE_CMP) ||
                         (mode == `CT_MODE_PWM);
      timer_output_pin <= pin_raw ^ output_invert;
    end
  end
endmodule
`default_nettype wire

// >>> compact_timer_consts.vh
// Register map, field positions and codes for the compact timer
`ifndef COMPACT_TIMER_CONSTS_VH
`define COMPACT_TIMER_CONSTS_VH

`define CT_ADDR_W 3
`define CT_OFF_CTRL0 3'h0
`define CT_OFF_CTRL1 3'h1
`define CT_OFF_CNT_LO 3'h2
`define CT_OFF_CNT_HI 3'h3
`define CT_OFF_CMPA_LO 3'h4
`define CT_OFF_CMPA_HI 3'h5
`define CT_OFF_CMPP 3'h6
`define CT_OFF_FLAGS 3'h7

`define CT_CTRL0_RST 8'h00
`define CT_CTRL1_RST 8'h00
`define CT_CTRL0_MASK 8'hf8

`define CT_B_PAUSE 7
`define CT_B_RUN 3
`define CT_B_CLR_SRC 0
`define CT_B_SWAP 1
`define CT_B_INVERT 2
`define CT_B_INIT 3
`define CT_B_FLAG_A 0
`define CT_B_FLAG_P 1

`define CT_MODE_CMP 2'h0
`define CT_MODE_PWM 2'h2
`define CT_MODE_TMR 2'h3

`define CT_ACT_KEEP 2'h0
`define CT_ACT_LOW 2'h1
`define CT_ACT_HIGH 2'h2
`define CT_ACT_TOGGLE 2'h3

`define CT_CLK_SYS4 3'h0
`define CT_CLK_SYS 3'h1
`define CT_CLK_H16 3'h2
`define CT_CLK_H64 3'h3
`define CT_CLK_TBC 3'h4
`define CT_CLK_H8 3'h5
`define CT_CLK_EXT_RISE 3'h6
`define CT_CLK_EXT_FALL 3'h7

`endif

// >>> compact_timer_tick.v
// Counting tick generator: prescaled internal clocks and external edges
`timescale 1ns/1ns
`default_nettype none
`include "compact_timer_consts.vh"
module compact_timer_tick (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Control
  input wire run,
  input wire [2:0] sel,
  input wire high_clk_tick,
  input wire time_base_tick,
  input wire external_count_input,
  // Tick out
  output reg tick
);
  reg [5:0] div_ff;
  reg ext_ff;
  reg [5:0] nxt_div;

  always @* begin
    nxt_div = div_ff + 6'h01;
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_ff <= 6'h00;
      ext_ff <= 1'b0;
    end else begin
      ext_ff <= external_count_input;
      if (!run)
        div_ff <= 6'h00;
      else if (sel == `CT_CLK_SYS4 || high_clk_tick)
        div_ff <= nxt_div;
    end
  end

  // Select one active tick per counting clock period
  always @* begin
    case (sel)
      `CT_CLK_SYS4: tick = (div_ff[1:0] == 2'h3);
      `CT_CLK_SYS: tick = 1'b1;
      `CT_CLK_H16: tick = high_clk_tick && (div_ff[3:0] == 4'hf);
      `CT_CLK_H64: tick = high_clk_tick && (div_ff == 6'h3f);
      `CT_CLK_TBC: tick = time_base_tick;
      `CT_CLK_H8: tick = high_clk_tick && (div_ff[2:0] == 3'h7);
      `CT_CLK_EXT_RISE: tick = external_count_input && !ext_ff;
      default: tick = !external_count_input && ext_ff;
    endcase
  end
endmodule
`default_nettype wire

// >>> compact_timer_regs.v
// Byte register file with the shared low-byte buffer
`timescale 1ns/1ns
`default_nettype none
`include "compact_timer_consts.vh"
module compact_timer_regs (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Register port
  input wire [2:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata_ff,
  // Block state
  input wire [15:0] count,
  input wire [1:0] flags,
  output reg [7:0] ctrl0_ff,
  output reg [7:0] ctrl1_ff,
  output reg [15:0] cmpa_ff,
  output reg [7:0] cmpp_ff,
  output reg [1:0] flag_clr
);
  reg [7:0] buf_ff;

  always @* begin
    flag_clr = 2'h0;
    if (wr && addr == `CT_OFF_FLAGS)
      flag_clr = wdata[1:0];
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl0_ff <= `CT_CTRL0_RST;
      ctrl1_ff <= `CT_CTRL1_RST;
      cmpa_ff <= 16'h0000;
      cmpp_ff <= 8'h00;
      buf_ff <= 8'h00;
      rdata_ff <= 8'h00;
    end else begin
      if (wr) begin
        if (addr == `CT_OFF_CTRL0)
          ctrl0_ff <= wdata & `CT_CTRL0_MASK;
        else if (addr == `CT_OFF_CTRL1)
          ctrl1_ff <= wdata;
        else if (addr == `CT_OFF_CMPA_LO)
          buf_ff <= wdata;
        else if (addr == `CT_OFF_CMPA_HI)
          cmpa_ff <= {wdata, buf_ff};
        else if (addr == `CT_OFF_CMPP)
          cmpp_ff <= wdata;
      end
      rdata_ff <= 8'h00;
      if (rd) begin
        if (addr == `CT_OFF_CTRL0)
          rdata_ff <= ctrl0_ff;
        else if (addr == `CT_OFF_CTRL1)
          rdata_ff <= ctrl1_ff;
        else if (addr == `CT_OFF_CNT_LO || addr == `CT_OFF_CMPA_LO)
          rdata_ff <= buf_ff;
        else if (addr == `CT_OFF_CNT_HI) begin
          rdata_ff <= count[15:8];
          buf_ff <= count[7:0];
        end else if (addr == `CT_OFF_CMPA_HI) begin
          rdata_ff <= cmpa_ff[15:8];
          buf_ff <= cmpa_ff[7:0];
        end else if (addr == `CT_OFF_CMPP)
          rdata_ff <= cmpp_ff;
        else
          rdata_ff <= {6'h00, flags};
      end
    end
  end
endmodule
`default_nettype wire

// >>> compact_timer_monitor.sv
// Port-level checker for the compact timer
`timescale 1ns/1ns
`default_nettype none
module compact_timer_monitor (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Register port
  input wire [2:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata,
  // Pin enable and flags
  input wire timer_output_en,
  input wire match_a_flag,
  input wire match_p_flag
);
  reg [7:0] c1_ff;
  wire wc1 = wr && addr == 3'h1;
  wire clr_a = wr && addr == 3'h7 && wdata[0];
  wire clr_p = wr && addr == 3'h7 && wdata[1];
  wire a_clr = c1_ff[0] && c1_ff[7:6] == 2'h0;
  // Shadow of the mode register
  always @(posedge ref_clk or posedge rst) begin
    if (rst)
      c1_ff <= 8'h00;
    else if (wc1)
      c1_ff <= wdata;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_quiet;
    !wc1 [*3];
  endsequence
  sequence s_rd_flags;
    rd && addr == 3'h7;
  endsequence
  property p_rd_idle;
    !rd |=> rdata == 8'h00;
  endproperty
  property p_fall_a;
    $fell(match_a_flag) |-> $past(clr_a) || $past(clr_a, 2);
  endproperty
  property p_fall_p;
    $fell(match_p_flag) |-> $past(clr_p) || $past(clr_p, 2);
  endproperty
  property p_rd_flags;
    s_rd_flags |=> rdata ==
      {6'h00, $past(match_p_flag), $past(match_a_flag)};
  endproperty
  property p_c0_rsvd;
    rd && addr == 3'h0 |=> rdata[2:0] == 3'h0;
  endproperty
  property p_c1_rd;
    rd && addr == 3'h1 |=> rdata == $past(c1_ff);
  endproperty
  property p_en;
    s_quiet |->
      timer_output_en == (c1_ff[7:6] == 2'h0 || c1_ff[7:6] == 2'h2);
  endproperty
  property p_no_p;
    $rose(match_p_flag) |-> !(a_clr && $past(a_clr, 3));
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not idle");
  a_fall_a: assert property (p_fall_a)
    else $error("A flag dropped unasked");
  a_fall_p: assert property (p_fall_p)
    else $error("P flag dropped unasked");
  a_rd_flags: assert property (p_rd_flags)
    else $error("flag read wrong");
  a_c0_rsvd: assert property (p_c0_rsvd)
    else $error("control zero low bits not zero");
  a_c1_rd: assert property (p_c1_rd)
    else $error("control one read wrong");
  a_en: assert property (p_en)
    else $error("pin enable wrong for mode");
  a_no_p: assert property (p_no_p)
    else $error("P flag raised with A clear");
endmodule
bind compact_timer compact_timer_monitor mon (.ref_clk(ref_clk),
  .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .timer_output_en(timer_output_en),
  .match_a_flag(match_a_flag), .match_p_flag(match_p_flag));
`default_nettype wire

// >>> tb_compact_timer.sv
// Self-checking bench for the compact timer
`timescale 1ns/1ns
`default_nettype none
module tb_compact_timer;
  reg ref_clk = 1'b0;
  reg rst = 1'b1;
  reg [2:0] addr = 3'h0;
  reg [7:0] wdata = 8'h00;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg ext = 1'b0;
  reg tbt = 1'b0;
  wire [7:0] rdata;
  wire pin, en, fa, fp;
  integer miscompares = 0;
  integer n_checks = 0;
  integer i, n;
  reg [7:0] d, h, l;
  reg [15:0] c0, c1;
  compact_timer DUT (.ref_clk(ref_clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .high_clk_tick(1'b1), .time_base_tick(tbt),
    .external_count_input(ext), .timer_output_pin(pin),
    .timer_output_en(en), .match_a_flag(fa), .match_p_flag(fp));
  initial forever #25 ref_clk = ~ref_clk;
  task check(input [15:0] seen, input [15:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("checks=%0d mismatches=%0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task idle(input integer k);
    repeat (k) @(posedge ref_clk);
  endtask
  task wreg(input [2:0] a, input [7:0] v);
    begin
      @(posedge ref_clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge ref_clk);
      wr <= 1'b0;
    end
  endtask
  task rreg(input [2:0] a, output [7:0] v);
    begin
      @(posedge ref_clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1 v = rdata;
    end
  endtask
  // High byte first so the low byte is latched alongside
  task rcnt(output [15:0] v);
    begin
      rreg(3'h3, h);
      rreg(3'h2, l);
      v = {h, l};
    end
  endtask
  // Mode changes only while stopped
  task start(input [7:0] m, input [7:0] c);
    begin
      wreg(3'h0, 8'h00);
      wreg(3'h1, m);
      wreg(3'h0, c);
    end
  endtask
  initial begin
    idle(3);
    rst <= 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      rreg(i[2:0], d);
      check(d, 16'h0000);
    end
    wreg(3'h4, 8'h34);
    wreg(3'h5, 8'h12);
    wreg(3'h3, 8'hff);
    rreg(3'h3, d);
    check(d, 16'h0000);
    rreg(3'h5, h);
    rreg(3'h4, l);
    check({h, l}, 16'h1234);
    start(8'h00, 8'h18);
    idle(40);
    wreg(3'h0, 8'h98);
    rcnt(c0);
    idle(10);
    rcnt(c1);
    check(c1, c0);
    wreg(3'h0, 8'h18);
    idle(10);
    rcnt(c1);
    check(c1 > c0, 16'h0001);
    wreg(3'h0, 8'h10);
    rcnt(c0);
    idle(5);
    rcnt(c1);
    check(c1, c0);
    wreg(3'h0, 8'h18);
    rcnt(c1);
    check(c1 < 16'h0010 && c0 > 16'h0020, 16'h0001);
    for (i = 0; i < 3; i = i + 1) begin
      wreg(3'h0, 8'h00);
      wreg(3'h0, (i == 2) ? 8'h48 : i ? 8'h78 : 8'h68);
      repeat (5) begin
        idle(4);
        ext <= 1'b1;
        tbt <= (i == 2);
        idle(1);
        tbt <= 1'b0;
        idle(3);
        ext <= 1'b0;
      end
      idle(4);
      rcnt(c0);
      check(c0, 16'h0005);
    end
    wreg(3'h4, 8'h03);
    wreg(3'h5, 8'h00);
    start(8'h31, 8'h18);
    for (i = 0; i < 100 && fa !== 1'b1; i = i + 1)
      idle(1);
    check(fa, 16'h0001);
    if (fa !== 1'b1)
      print_verdict;
    idle(10);
    d[0] = pin;
    idle(3);
    check(pin != d[0], 16'h0001);
    check(fp, 16'h0000);
    wreg(3'h6, 8'h01);
    wreg(3'h4, 8'h00);
    wreg(3'h5, 8'h01);
    start(8'h20, 8'h18);
    wreg(3'h7, 8'h03);
    idle(600);
    check(pin, 16'h0001);
    check({fp, fa}, 16'h0003);
    wreg(3'h7, 8'h03);
    rreg(3'h7, d);
    check(d, 16'h0000);
    wreg(3'h0, 8'h10);
    wreg(3'h0, 8'h18);
    idle(5);
    check(pin, 16'h0000);
    start(8'h10, 8'h18);
    idle(600);
    check(pin, 16'h0000);
    start(8'h24, 8'h18);
    idle(5);
    check(pin, 16'h0001);
    start(8'h98, 8'h18);
    idle(5);
    check(pin, 16'h0001);
    start(8'h88, 8'h18);
    idle(5);
    check(pin, 16'h0000);
    wreg(3'h4, 8'h80);
    wreg(3'h5, 8'h00);
    for (i = 0; i < 2; i = i + 1) begin
      start(i ? 8'haa : 8'ha8, 8'h18);
      idle(5);
      n = 0;
      repeat (512) begin
        idle(1);
        n = n + pin;
      end
      check(i ? n == 512 : n >= 250 && n <= 262, 16'h1);
    end
    start(8'hc0, 8'h18);
    idle(5);
    check(en, 16'h0000);
    print_verdict;
  end
endmodule
`default_nettype wire
